//--- hw/orl_consts.svh
// constants for the output relay latch and force block
// assumes one 25 MHz system clock and a plain strobe register port
`ifndef ORL_CONSTS_SVH
`define ORL_CONSTS_SVH
`define ORL_NUM_REL 6
`define ORL_NUM_SIG 7
`define ORL_ADDR_W 8
// register byte addresses
`define ORL_OFS_CTRL 8'h00
`define ORL_OFS_LATCH_EN 8'h04
`define ORL_OFS_RELAY_INV 8'h08
`define ORL_OFS_EXEMPT 8'h0C
`define ORL_OFS_FORCE 8'h10
`define ORL_OFS_CMD 8'h14
`define ORL_OFS_STATUS 8'h18
`define ORL_OFS_SIG_INV0 8'h20
`define ORL_SIG_INV_STEP 8'h04
// control field positions
`define ORL_CTRL_DIS_EN 0
`define ORL_CTRL_DIS_CMD 1
`define ORL_CTRL_GRP_LO 2
`define ORL_CMD_ACK 0
`define ORL_ST_LATCH_LO 8
`define ORL_ST_SYSOK 16
// reset values
`define ORL_RST_LATCH_EN 6'h3F
`define ORL_RST_RELAY_INV 6'h00
`define ORL_RST_EXEMPT 6'h00
`define ORL_RST_FORCE 12'h000
`define ORL_RST_GRP 2'h0
`endif

//--- hw/orl_pkg.sv
// types for the output relay latch and force block
// assumes orl_consts.svh is on the include path
`include "orl_consts.svh"
package orl_pkg;
  typedef enum logic [1:0] {ORL_NORMAL, ORL_DEENERGIZED, ORL_ENERGIZED} orl_force_e;
  typedef logic [`ORL_NUM_REL-1:0] orl_rel_t;
  typedef logic [`ORL_NUM_SIG-1:0] orl_sig_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } orl_sync_s;
  typedef struct packed {
    logic latch;
    logic ack_d;
  } orl_chan_s;
  typedef struct packed {
    logic dis_en;
    logic dis_cmd;
    logic [1:0] grp;
    orl_rel_t latch_en;
    orl_rel_t relay_inv;
    orl_rel_t exempt;
    logic [2*`ORL_NUM_REL-1:0] force_set;
    logic [`ORL_NUM_REL*`ORL_NUM_SIG-1:0] sig_inv;
    logic scada_ack;
    logic restore_pend;
    logic restore;
    orl_rel_t coil;
    orl_rel_t latch_out;
    logic sysok;
    logic [31:0] rdata;
  } orl_top_s;
endpackage

//--- hw/orl_sync.sv
// two-stage synchroniser with a one-cycle rising-edge pulse
// assumes an asynchronous pin input and the system clock
`timescale 1ns/100ps
`default_nettype none
module orl_sync
  import orl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and result
  input wire logic pin,
  output logic rise
);
  orl_sync_s st_ff;
  orl_sync_s nxt_st;

  always_comb
  begin
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign rise = st_ff.s2 & ~st_ff.s3;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  pulse_one_a: assert property (rise |=> !rise)
    else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

//--- hw/orl_chan.sv
// one output relay: signal combine, latch, acknowledgement
// assumes assigned and acknowledge signals come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module orl_chan
  import orl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire orl_sig_t sig,
  input wire orl_sig_t sig_inv,
  input wire logic latch_en,
  // acknowledgement and hold
  input wire logic ack_sig,
  input wire logic glob_ack,
  input wire logic hold,
  // restore after power-up
  input wire logic restore,
  input wire logic restore_val,
  // state
  output logic comb,
  output logic latch_q,
  output logic value
);
  orl_chan_s st_ff;
  orl_chan_s nxt_st;
  logic own_ack;
  logic clr;

  assign comb = |(sig ^ sig_inv);
  assign own_ack = ack_sig & ~st_ff.ack_d & latch_en;
  assign clr = (own_ack | glob_ack) & ~comb & ~hold;

  always_comb
  begin
    nxt_st.ack_d = ack_sig;
    if (restore)
      nxt_st.latch = restore_val;
    else
      // set wins; latch_en gates setting and the own acknowledge, so a held latch survives it
      nxt_st.latch = (latch_en & comb) | (st_ff.latch & ~clr);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign latch_q = st_ff.latch;
  assign value = comb | st_ff.latch;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  restore_load_a: assert property (restore |=> latch_q == $past(restore_val))
    else $error("latch not restored");
  latch_keep_a: assert property (latch_q && !restore && !glob_ack && !ack_sig |=> latch_q)
    else $error("latch lost without acknowledgement");
  clear_cause_a: assert property ($fell(latch_q) |-> $past(glob_ack || own_ack || restore))
    else $error("latch cleared without acknowledgement");
  ack_guard_a: assert property (latch_q && (comb || hold) && !restore |=> latch_q)
    else $error("acknowledge taken while set or held");
  follow_a: assert property (!latch_en && !latch_q && !restore |=> !latch_q)
    else $error("relay latched while latching is off");
endmodule
`default_nettype wire

//--- hw/orl_top.sv
// output relay latch, disarm and force control with system-ok contact
// assumes register strobes from same-clock logic, key and external ack from pins
//
// Functional notes
// - latched outputs reload their stored state after power returns
// - latched state survives reconfiguration, also latch switched off
// - a latched output clears only through an acknowledgement
// - system-ok contact has no user settings
// - front-panel clear key acknowledges all relays
// - per-relay acknowledge signal acts only while latching is on
// - external acknowledge rising clears all relays together
// - supervisory acknowledge command clears all relays together
// - system-ok contact energized only without internal fault
// - system-ok off during boot, then on with its led
// - disarm command takes only with enable set in the same write; command unavailable while enable off
// - zone interlock and supervision outputs are exempt from disarm
// - per-relay force: normal, energized, de-energized; default normal
// - group force overrides every individual force
// - disarm command and enable reset inactive
// - acknowledge needs set signals gone and retention time expired
// - unlatched relay follows its combined signals
// - seven invertible signals ORed, result invertible too
`timescale 1ns/100ps
`default_nettype none
module orl_top
  import orl_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // register port
  input wire logic [`ORL_ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // protection signals, relay i uses bits 7*i+6..7*i
  input wire logic [`ORL_NUM_REL*`ORL_NUM_SIG-1:0] ASSIGN_SIG,
  input wire orl_rel_t ACK_SIG,
  input wire orl_rel_t HOLD_ACT,
  // acknowledge pins
  input wire logic CLEAR_KEY,
  input wire logic EXTERNAL_ACK_MODULE,
  // device state
  input wire logic BOOT_DONE,
  input wire logic INT_FAULT,
  // stored latch image
  input wire orl_rel_t NV_LATCH,
  output orl_rel_t LATCH_STATE,
  // relay coils
  output orl_rel_t RELAY_COIL,
  output logic SYSTEM_OK_CONTACT,
  output logic SYSTEM_OK_LED
);
  orl_top_s st_ff;
  orl_top_s nxt_st;
  logic key_rise;
  logic ext_rise;
  logic glob_ack;
  logic dis_act;
  orl_force_e grp_f;
  orl_rel_t ch_latch;
  orl_rel_t ch_val;
  orl_rel_t ch_comb;

  function automatic orl_force_e force_dec(input logic [1:0] code);
    unique case (code)
      2'h1: force_dec = ORL_DEENERGIZED;
      2'h2: force_dec = ORL_ENERGIZED;
      default: force_dec = ORL_NORMAL;
    endcase
  endfunction

  function automatic logic hit(input logic [`ORL_ADDR_W-1:0] ofs);
    hit = REG_ADDR == ofs;
  endfunction

  orl_sync u_key
  (
    .clk(CLK_SYS),
    .rst(RST),
    .pin(CLEAR_KEY),
    .rise(key_rise)
  );

  orl_sync u_ext
  (
    .clk(CLK_SYS),
    .rst(RST),
    .pin(EXTERNAL_ACK_MODULE),
    .rise(ext_rise)
  );

  assign glob_ack = key_rise | ext_rise | st_ff.scada_ack;

  genvar gi;
  generate
    for (gi = 0; gi < `ORL_NUM_REL; gi++)
    begin : g_chan
      orl_chan u_chan
      (
        .clk(CLK_SYS),
        .rst(RST),
        .sig(ASSIGN_SIG[gi*`ORL_NUM_SIG +: `ORL_NUM_SIG]),
        .sig_inv(st_ff.sig_inv[gi*`ORL_NUM_SIG +: `ORL_NUM_SIG]),
        .latch_en(st_ff.latch_en[gi]),
        .ack_sig(ACK_SIG[gi]),
        .glob_ack(glob_ack),
        .hold(HOLD_ACT[gi]),
        .restore(st_ff.restore),
        .restore_val(NV_LATCH[gi]),
        .comb(ch_comb[gi]),
        .latch_q(ch_latch[gi]),
        .value(ch_val[gi])
      );
    end
  endgenerate

  assign dis_act = st_ff.dis_en & st_ff.dis_cmd;
  assign grp_f = force_dec(st_ff.grp);

  always_comb
  begin
    logic v;
    orl_force_e f;
    v = 1'b0;
    f = ORL_NORMAL;
    nxt_st = st_ff;
    nxt_st.scada_ack = 1'b0;
    // capture the stored latch image one cycle after reset release
    nxt_st.restore_pend = 1'b0;
    nxt_st.restore = st_ff.restore_pend;
    if (REG_WR)
    begin
      if (hit(`ORL_OFS_CTRL))
      begin
        nxt_st.dis_en = REG_WDATA[`ORL_CTRL_DIS_EN];
        // command only takes when the same write also sets the enable
        nxt_st.dis_cmd = REG_WDATA[`ORL_CTRL_DIS_CMD] & REG_WDATA[`ORL_CTRL_DIS_EN];
        nxt_st.grp = REG_WDATA[`ORL_CTRL_GRP_LO +: 2];
      end
      if (hit(`ORL_OFS_LATCH_EN))
        nxt_st.latch_en = REG_WDATA[`ORL_NUM_REL-1:0];
      if (hit(`ORL_OFS_RELAY_INV))
        nxt_st.relay_inv = REG_WDATA[`ORL_NUM_REL-1:0];
      if (hit(`ORL_OFS_EXEMPT))
        nxt_st.exempt = REG_WDATA[`ORL_NUM_REL-1:0];
      if (hit(`ORL_OFS_FORCE))
        nxt_st.force_set = REG_WDATA[2*`ORL_NUM_REL-1:0];
      if (hit(`ORL_OFS_CMD))
        nxt_st.scada_ack = REG_WDATA[`ORL_CMD_ACK];
      for (int i = 0; i < `ORL_NUM_REL; i++)
      begin
        if (hit(`ORL_OFS_SIG_INV0 + `ORL_SIG_INV_STEP * 8'(i)))
          nxt_st.sig_inv[i*`ORL_NUM_SIG +: `ORL_NUM_SIG] = REG_WDATA[`ORL_NUM_SIG-1:0];
      end
    end
    // read data stand only in the cycle after the strobe
    nxt_st.rdata = '0;
    if (REG_RD)
    begin
      if (hit(`ORL_OFS_CTRL))
      begin
        nxt_st.rdata[`ORL_CTRL_DIS_EN] = st_ff.dis_en;
        nxt_st.rdata[`ORL_CTRL_DIS_CMD] = st_ff.dis_cmd;
        nxt_st.rdata[`ORL_CTRL_GRP_LO +: 2] = st_ff.grp;
      end
      if (hit(`ORL_OFS_LATCH_EN))
        nxt_st.rdata[`ORL_NUM_REL-1:0] = st_ff.latch_en;
      if (hit(`ORL_OFS_RELAY_INV))
        nxt_st.rdata[`ORL_NUM_REL-1:0] = st_ff.relay_inv;
      if (hit(`ORL_OFS_EXEMPT))
        nxt_st.rdata[`ORL_NUM_REL-1:0] = st_ff.exempt;
      if (hit(`ORL_OFS_FORCE))
        nxt_st.rdata[2*`ORL_NUM_REL-1:0] = st_ff.force_set;
      if (hit(`ORL_OFS_STATUS))
      begin
        nxt_st.rdata[`ORL_NUM_REL-1:0] = st_ff.coil;
        nxt_st.rdata[`ORL_ST_LATCH_LO +: `ORL_NUM_REL] = st_ff.latch_out;
        nxt_st.rdata[`ORL_ST_SYSOK] = st_ff.sysok;
      end
      for (int i = 0; i < `ORL_NUM_REL; i++)
      begin
        if (hit(`ORL_OFS_SIG_INV0 + `ORL_SIG_INV_STEP * 8'(i)))
          nxt_st.rdata[`ORL_NUM_SIG-1:0] = st_ff.sig_inv[i*`ORL_NUM_SIG +: `ORL_NUM_SIG];
      end
    end
    // clearing the enable withdraws a pending command
    if (!nxt_st.dis_en)
      nxt_st.dis_cmd = 1'b0;
    for (int i = 0; i < `ORL_NUM_REL; i++)
    begin
      v = ch_val[i] ^ st_ff.relay_inv[i];
      if (dis_act && !ch_latch[i] && !HOLD_ACT[i] && !st_ff.exempt[i])
        v = 1'b0;
      f = (grp_f != ORL_NORMAL) ? grp_f : force_dec(st_ff.force_set[2*i +: 2]);
      if (f == ORL_ENERGIZED)
        v = 1'b1;
      else if (f == ORL_DEENERGIZED)
        v = 1'b0;
      nxt_st.coil[i] = v;
    end
    nxt_st.latch_out = ch_latch;
    // fixed behaviour, no register reaches it
    nxt_st.sysok = BOOT_DONE & ~INT_FAULT;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      st_ff <= '0;
      st_ff.latch_en <= `ORL_RST_LATCH_EN;
      st_ff.relay_inv <= `ORL_RST_RELAY_INV;
      st_ff.exempt <= `ORL_RST_EXEMPT;
      st_ff.force_set <= `ORL_RST_FORCE;
      st_ff.grp <= `ORL_RST_GRP;
      st_ff.restore_pend <= 1'b1;
      st_ff.dis_en <= 1'b0;
      st_ff.dis_cmd <= 1'b0;
    end
    else
      st_ff <= nxt_st;
  end

  assign REG_RDATA = st_ff.rdata;
  assign RELAY_COIL = st_ff.coil;
  assign LATCH_STATE = st_ff.latch_out;
  assign SYSTEM_OK_CONTACT = st_ff.sysok;
  assign SYSTEM_OK_LED = st_ff.sysok;

  sequence disarm_armed_s;
    st_ff.dis_en && st_ff.dis_cmd && st_ff.grp == 2'h0;
  endsequence
  sequence free_relay3_s;
    !ch_latch[3] && !HOLD_ACT[3] && !st_ff.exempt[3] && st_ff.force_set[7:6] == 2'h0;
  endsequence

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sysok_fault_a: assert property (INT_FAULT |=> !SYSTEM_OK_CONTACT)
    else $error("system-ok energized with internal fault");
  sysok_boot_a: assert property (!RST && BOOT_DONE && !INT_FAULT
      |=> SYSTEM_OK_CONTACT && SYSTEM_OK_LED)
    else $error("system-ok not energized after boot");
  sysok_low_a: assert property (!BOOT_DONE |=> !SYSTEM_OK_CONTACT && !SYSTEM_OK_LED)
    else $error("system-ok energized during boot");
  sysok_fixed_a: assert property (!RST
      |=> SYSTEM_OK_CONTACT == $past(BOOT_DONE && !INT_FAULT))
    else $error("system-ok not fixed to boot and fault state");
  latch_image_a: assert property (!RST |=> LATCH_STATE == $past(ch_latch))
    else $error("latch image not presented");
  disarm_gate_a: assert property (!st_ff.dis_en |-> !st_ff.dis_cmd)
    else $error("disarm command without enable");
  disarm_free_a: assert property (disarm_armed_s ##0 free_relay3_s |=> !RELAY_COIL[3])
    else $error("disarm did not drop free relay");
  disarm_latched_a: assert property (disarm_armed_s ##0 ch_latch[0]
      && !st_ff.relay_inv[0] && st_ff.force_set[1:0] == 2'h0 |=> RELAY_COIL[0])
    else $error("disarm dropped a latched relay");
  group_force_a: assert property (st_ff.grp == 2'h2 |=> RELAY_COIL == '1)
    else $error("group force energized not applied");
  group_deen_a: assert property (st_ff.grp == 2'h1 |=> RELAY_COIL == '0)
    else $error("group force de-energized not applied");
  key_ack_a: assert property (key_rise || ext_rise |-> glob_ack)
    else $error("key or external edge not merged into acknowledge");
  scada_ack_a: assert property (REG_WR && REG_ADDR == `ORL_OFS_CMD
      && REG_WDATA[`ORL_CMD_ACK] |=> glob_ack ##1 (!st_ff.scada_ack
      || (REG_WR && REG_ADDR == `ORL_OFS_CMD)))
    else $error("supervisory acknowledge not one pulse");
  reset_dis_a: assert property (@(posedge CLK_SYS) RST |=> !st_ff.dis_en && !st_ff.dis_cmd)
    else $error("disarm not inactive after reset");

  // per-relay force, disarm, acknowledge and follow checks
  generate
    for (gi = 0; gi < `ORL_NUM_REL; gi++)
    begin : g_chk
      orl_force_e own_f;
      assign own_f = force_dec(st_ff.force_set[2*gi +: 2]);
      sequence rel_normal_s;
        grp_f == ORL_NORMAL && own_f == ORL_NORMAL;
      endsequence
      force_on_a: assert property (grp_f == ORL_NORMAL
          && own_f == ORL_ENERGIZED |=> RELAY_COIL[gi])
        else $error("forced relay not energized");
      force_off_a: assert property (grp_f == ORL_NORMAL
          && own_f == ORL_DEENERGIZED |=> !RELAY_COIL[gi])
        else $error("forced relay not de-energized");
      disarm_keep_a: assert property (disarm_armed_s ##0 rel_normal_s
          ##0 (ch_latch[gi] || HOLD_ACT[gi] || st_ff.exempt[gi])
          |=> RELAY_COIL[gi] == $past(ch_val[gi] ^ st_ff.relay_inv[gi]))
        else $error("disarm dropped a protected relay");
      glob_clear_a: assert property (glob_ack && !ch_comb[gi] && !HOLD_ACT[gi]
          && !st_ff.restore |=> !ch_latch[gi])
        else $error("global acknowledge did not clear latch");
      own_ack_off_a: assert property (!st_ff.latch_en[gi] && ch_latch[gi]
          && !glob_ack && !st_ff.restore |=> ch_latch[gi])
        else $error("latch cleared by own signal with latching off");
      latch_set_a: assert property (!RST && st_ff.latch_en[gi] && ch_comb[gi]
          && !st_ff.restore |=> ch_latch[gi])
        else $error("active relay did not latch");
      follow_coil_a: assert property (!RST && !st_ff.latch_en[gi] && !ch_latch[gi]
          && !dis_act ##0 rel_normal_s
          |=> RELAY_COIL[gi] == $past(ch_comb[gi] ^ st_ff.relay_inv[gi]))
        else $error("unlatched relay coil not following signals");
    end
  endgenerate
endmodule
`default_nettype wire

//--- sim/orl_nv_model.sv
// nonvolatile latch image store at the far side of the relay block
// assumes the block has reloaded its latches within seven edges of reset release
`timescale 1ns/100ps
`default_nettype none
module orl_nv_model
  import orl_pkg::*;
(
  // clock and power state
  input wire logic clk,
  input wire logic rst,
  // latch image
  input wire orl_rel_t latch_state,
  output var orl_rel_t nv_latch
);
  logic [2:0] age_ff;
  orl_rel_t img_ff = 6'h00;

  assign nv_latch = img_ff;

  // saving waits for the reload, else a power cycle would wipe the image
  always @(posedge clk)
  begin
    if (rst)
      age_ff <= 3'h0;
    else if (age_ff != 3'h7)
      age_ff <= age_ff + 3'h1;
    if (!rst && age_ff == 3'h7)
      img_ff <= latch_state;
  end
endmodule
`default_nettype wire

//--- sim/orl_top_tb_top.sv
// self-checking bench for the relay latch, disarm and force block
// assumes orl_consts.svh on the include path and the store model beside it
`timescale 1ns/100ps
`default_nettype none
`include "orl_consts.svh"
module orl_top_tb_top
  import orl_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [41:0] asig = 42'h0;
  orl_rel_t acks = 6'h00;
  orl_rel_t hold = 6'h00;
  logic key = 1'b0;
  logic exa = 1'b0;
  logic boot = 1'b0;
  logic flt = 1'b0;
  logic [31:0] rdata;
  orl_rel_t nv;
  orl_rel_t lst;
  orl_rel_t coil;
  logic sok;
  logic led;
  int num_errors = 0;
  int checked = 0;

  always #20 clk = ~clk;

  orl_top uut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ASSIGN_SIG(asig), .ACK_SIG(acks),
    .HOLD_ACT(hold), .CLEAR_KEY(key), .EXTERNAL_ACK_MODULE(exa), .BOOT_DONE(boot),
    .INT_FAULT(flt), .NV_LATCH(nv), .LATCH_STATE(lst), .RELAY_COIL(coil),
    .SYSTEM_OK_CONTACT(sok), .SYSTEM_OK_LED(led));

  orl_nv_model store (.clk(clk), .rst(rst), .latch_state(lst), .nv_latch(nv));

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cc(input logic [31:0] e);
    w(3);
    cmp({26'h0, coil}, e);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask

  // 0 clear key, 1 external pin, 2 supervisory command, 3 relay 0 own signal
  task automatic ack(input int k);
    if (k == 2)
      wreg(`ORL_OFS_CMD, 32'h1);
    else
    begin
      @(posedge clk);
      key <= (k == 0);
      exa <= (k == 1);
      acks <= {5'h00, k == 3};
      w(3);
      @(posedge clk);
      key <= 1'b0;
      exa <= 1'b0;
      acks <= 6'h00;
    end
    w(6);
  endtask

  task automatic latch0();
    @(posedge clk);
    asig[0] <= 1'b1;
    w(3);
    @(posedge clk);
    asig[0] <= 1'b0;
    w(3);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    w(2);
    rreg(`ORL_OFS_CTRL, 32'h0);
    rreg(`ORL_OFS_LATCH_EN, 32'h3F);
    rreg(`ORL_OFS_FORCE, 32'h0);
    cmp({30'h0, led, sok}, 32'h0);
    @(posedge clk);
    boot <= 1'b1;
    w(3);
    cmp({30'h0, led, sok}, 32'h3);
    @(posedge clk);
    flt <= 1'b1;
    w(3);
    cmp({30'h0, led, sok}, 32'h0);
    @(posedge clk);
    flt <= 1'b0;
    wreg(`ORL_OFS_LATCH_EN, 32'h1);
    @(posedge clk);
    asig <= 42'h80;
    cc(32'h2);
    @(posedge clk);
    asig <= 42'h2000;
    cc(32'h2);
    @(posedge clk);
    asig <= 42'h0;
    wreg(`ORL_OFS_SIG_INV0 + `ORL_SIG_INV_STEP, 32'h1);
    cc(32'h2);
    wreg(`ORL_OFS_RELAY_INV, 32'h2);
    cc(32'h0);
    wreg(`ORL_OFS_SIG_INV0 + `ORL_SIG_INV_STEP, 32'h0);
    wreg(`ORL_OFS_RELAY_INV, 32'h0);
    cc(32'h0);
    latch0();
    rreg(`ORL_OFS_STATUS, 32'h10101);
    @(posedge clk);
    asig[0] <= 1'b1;
    ack(0);
    cc(32'h1);
    @(posedge clk);
    asig[0] <= 1'b0;
    hold <= 6'h01;
    ack(0);
    cc(32'h1);
    @(posedge clk);
    hold <= 6'h00;
    wreg(`ORL_OFS_LATCH_EN, 32'h0);
    ack(3);
    rreg(`ORL_OFS_STATUS, 32'h10101);
    ack(1);
    cc(32'h0);
    wreg(`ORL_OFS_LATCH_EN, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      latch0();
      cc(32'h1);
      ack(k);
      cc(32'h0);
    end
    // relay 3 active but forced off, relay 2 forced on
    @(posedge clk);
    asig <= 42'h200000;
    wreg(`ORL_OFS_FORCE, 32'h60);
    cc(32'h4);
    for (int g = 1; g < 4; g++)
    begin
      wreg(`ORL_OFS_CTRL, {28'h0, g[1:0], 2'h0});
      cc(g == 1 ? 32'h0 : g == 2 ? 32'h3F : 32'h4);
    end
    wreg(`ORL_OFS_CTRL, 32'h0);
    wreg(`ORL_OFS_FORCE, 32'h0);
    cc(32'h8);
    // relay 0 latched, 3 free, 4 held, 5 exempt
    wreg(`ORL_OFS_EXEMPT, 32'h20);
    @(posedge clk);
    asig <= 42'h810200001;
    hold <= 6'h10;
    cc(32'h39);
    wreg(`ORL_OFS_CTRL, 32'h2);
    rreg(`ORL_OFS_CTRL, 32'h0);
    cc(32'h39);
    wreg(`ORL_OFS_CTRL, 32'h3);
    rreg(`ORL_OFS_CTRL, 32'h3);
    cc(32'h31);
    wreg(`ORL_OFS_CTRL, 32'h0);
    cc(32'h39);
    @(posedge clk);
    asig <= 42'h0;
    hold <= 6'h00;
    w(12);
    cc(32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    w(8);
    cmp({26'h0, coil}, 32'h1);
    ack(0);
    cc(32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
